// >>> core/fpw_core.sv
// four channel pwm core with prescaler, scalers and apb register slave
`timescale 1ns/1ps
`default_nettype none
module fpw_core (
  input  wire logic                 clk,             // 100 MHz E clock
  input  wire logic                 nrst,            // async reset, active low
  input  wire fpw_pkg::fpw_apb_req_s apbReq,         // apb request group
  output logic [31:0]               prdata,          // read data
  output logic                      pready,          // always ready
  output logic                      pslverr,         // unmapped access
  input  wire logic                 specialModeFlag, // special mode strap
  input  wire logic [3:0]           pinDirectionBits,// port direction bits
  input  wire logic [3:0]           gpioData,        // port data latch
  output logic [3:0]                pinOut,          // pin drive level
  output logic [3:0]                pinOe_n          // pin output enable, low drives
);
  // register state
  logic [7:0] concat_q, selPol_q, scal_q [2], scnt_q [2];
  logic [7:0] cnt_q [4], cnt_d [4], perB_q [4], perW_q [4], perW_d [4];
  logic [7:0] dtyB_q [4], dtyW_q [4], dtyW_d [4];
  logic [3:0] enable_q, up_q, up_d, active_q, pinOut_q;
  logic [6:0] pres_q;
  logic [2:0] test_q;
  logic       center_q;
  logic [1:0] sPhase_q;

  // apb decode
  logic [7:0] addr;
  logic       apbWr, apbRd, mapped;
  logic [3:0] chSel, wrCount, wrPeriod, wrDuty;
  logic       presWr, clrInh, perInh, scalInh;
  logic [1:0] scaleWr;
  assign addr     = apbReq.paddr;
  assign apbWr    = apbReq.psel & apbReq.penable & apbReq.pwrite;
  assign apbRd    = apbReq.psel & apbReq.penable & ~apbReq.pwrite;
  assign mapped   = (addr[1:0] == 2'h0) && (addr <= fpw_pkg::ADDR_TEST);
  assign chSel    = 4'h1 << addr[3:2];
  assign wrCount  = (apbWr && addr[7:4] == fpw_pkg::GRP_COUNT)  ? chSel : 4'h0;
  assign wrPeriod = (apbWr && addr[7:4] == fpw_pkg::GRP_PERIOD) ? chSel : 4'h0;
  assign wrDuty   = (apbWr && addr[7:4] == fpw_pkg::GRP_DUTY)   ? chSel : 4'h0;
  // prescaler writes are ignored outside special mode
  assign presWr   = apbWr && addr == fpw_pkg::ADDR_PRESCALE && specialModeFlag;
  assign scaleWr  = {apbWr && addr == fpw_pkg::ADDR_SCALE_VAL1,
                     apbWr && addr == fpw_pkg::ADDR_SCALE_VAL0};
  assign clrInh   = specialModeFlag & test_q[fpw_pkg::POS_CLR_INH];
  assign perInh   = specialModeFlag & test_q[fpw_pkg::POS_PER_INH];
  assign scalInh  = specialModeFlag & test_q[fpw_pkg::POS_SCAL_INH];
  assign pready   = 1'b1;
  assign pslverr  = apbReq.psel & apbReq.penable & ~mapped;

  // read mux; reads have no side effects anywhere
  logic [7:0] rdByte;
  always_comb
  begin
    rdByte = fpw_pkg::RESET_BYTE;
    case (addr[7:4])
      fpw_pkg::GRP_COUNT:  rdByte = cnt_q[addr[3:2]];
      fpw_pkg::GRP_PERIOD: rdByte = perB_q[addr[3:2]];
      fpw_pkg::GRP_DUTY:   rdByte = dtyB_q[addr[3:2]];
      default:
      begin
        case (addr)
          fpw_pkg::ADDR_CLK_CONCAT: rdByte = concat_q;
          fpw_pkg::ADDR_SEL_POL:    rdByte = selPol_q;
          fpw_pkg::ADDR_ENABLE:     rdByte = {4'h0, enable_q};
          fpw_pkg::ADDR_PRESCALE:   rdByte = {1'b0, pres_q};
          fpw_pkg::ADDR_SCALE_VAL0: rdByte = scal_q[0];
          fpw_pkg::ADDR_SCALE_CNT0: rdByte = scnt_q[0];
          fpw_pkg::ADDR_SCALE_VAL1: rdByte = scal_q[1];
          fpw_pkg::ADDR_SCALE_CNT1: rdByte = scnt_q[1];
          fpw_pkg::ADDR_MODE:       rdByte = {7'h00, center_q};
          fpw_pkg::ADDR_TEST:       rdByte = {5'h00, test_q};
          default:                  rdByte = fpw_pkg::RESET_BYTE;
        endcase
      end
    endcase
  end
  assign prdata = (apbRd && mapped) ? {24'h000000, rdByte} : 32'h00000000;

  // field views
  logic [1:0] joinPair;
  logic [2:0] presSel [2];
  logic [3:0] clkSel, polarity;
  assign joinPair   = {concat_q[fpw_pkg::POS_JOIN_UP], concat_q[fpw_pkg::POS_JOIN_LOW]};
  assign presSel[0] = concat_q[fpw_pkg::POS_PRESC_A +: 3];
  assign presSel[1] = concat_q[fpw_pkg::POS_PRESC_B +: 3];
  assign clkSel     = selPol_q[fpw_pkg::POS_CLKSEL +: 4];
  assign polarity   = selPol_q[fpw_pkg::POS_POL +: 4];

  // prescaler tap: E divided by 2^sel, one pulse per 2^sel counts
  function automatic logic fpwDiv(input logic [6:0] pres, input logic [2:0] sel);
    logic [6:0] mask;
    mask = (7'h01 << sel) - 7'h01;
    fpwDiv = (pres | ~mask) == fpw_pkg::PRES_FULL;
  endfunction

  // one counter step for an 8-bit or joined 16-bit channel
  function automatic fpw_pkg::fpw_step_s fpwStep(input logic [15:0] c, per, dty,
                                                  input logic up, center, wide, noReset);
    logic [15:0] inc;
    logic        allOnes;
    fpwStep = '0;
    inc = wide ? c + 16'h0001 : {8'h00, c[7:0] + 8'h01};
    allOnes = wide ? (dty == 16'hFFFF) : (dty[7:0] == 8'hFF);
    // high phase for polarity 1; duty at or above period pins the level
    fpwStep.level = ((center ? (up ? c < dty : c <= dty) : (c <= dty)) || dty >= per)
                    && !(allOnes && per != 16'h0000);
    fpwStep.up = up;
    fpwStep.cnt = inc;
    if (!center && c == per && !noReset)
    begin
      fpwStep.cnt  = 16'h0000;
      fpwStep.roll = 1'b1;
    end
    else if (center && up && c >= per)
    begin
      fpwStep.up  = 1'b0;
      fpwStep.cnt = (c != 16'h0000) ? c - 16'h0001 : c;
    end
    else if (center && !up && c == 16'h0000)
    begin
      fpwStep.up   = 1'b1;
      fpwStep.roll = 1'b1;
      fpwStep.cnt  = (per != 16'h0000) ? inc : c;
    end
    else if (center && !up)
      fpwStep.cnt = c - 16'h0001;
  endfunction

  // clock chain: prescaler only runs while some channel is on
  logic       running;
  logic [1:0] abTick, sTick;
  logic [6:0] pres_d;
  assign running = |enable_q;
  assign abTick  = {running & fpwDiv(pres_q, presSel[1]),
                    running & fpwDiv(pres_q, presSel[0])};
  assign sTick   = {abTick[1] && scnt_q[1] == 8'h00 && sPhase_q[1],
                    abTick[0] && scnt_q[0] == 8'h00 && sPhase_q[0]};
  assign pres_d  = presWr ? apbReq.pwdata[6:0] : (running ? pres_q + 7'h01 : pres_q);

  // per-channel clock and enable; a joined pair runs on its high channel's enable
  logic [3:0] unitEn, chTick, effSel;
  assign effSel = {clkSel[3], joinPair[1] ? clkSel[3] : clkSel[2],
                   clkSel[1], joinPair[0] ? clkSel[1] : clkSel[0]};
  assign unitEn = {joinPair[1] ? enable_q[2] : enable_q[3], enable_q[2],
                   joinPair[0] ? enable_q[0] : enable_q[1], enable_q[0]};
  // gating whole clock-enable pulses means a channel never sees a runt tick
  assign chTick = ((effSel & {sTick[1], sTick[1], sTick[0], sTick[0]})
                   | (~effSel & {abTick[1], abTick[1], abTick[0], abTick[0]}))
                  & unitEn;

  // counter stepping, double-buffer transfer and counter writes
  logic [3:0] roll, level;
  always_comb
  begin
    fpw_pkg::fpw_step_s r;
    r = '0;
    cnt_d = cnt_q;
    up_d = up_q;
    roll = 4'h0;
    level = 4'h0;
    for (int p = 0; p < 2; p++)
    begin
      if (joinPair[p])
      begin
        r = fpwStep({cnt_q[2*p], cnt_q[2*p+1]}, {perW_q[2*p], perW_q[2*p+1]},
                    {dtyW_q[2*p], dtyW_q[2*p+1]}, up_q[2*p], center_q, 1'b1, perInh);
        level[2*p] = r.level;
        if (chTick[2*p])
        begin
          {cnt_d[2*p], cnt_d[2*p+1]} = r.cnt;
          up_d[2*p] = r.up;
          roll[2*p] = r.roll;
          roll[2*p+1] = r.roll;
        end
      end
      else
      begin
        for (int j = 2*p; j < 2*p+2; j++)
        begin
          r = fpwStep({8'h00, cnt_q[j]}, {8'h00, perW_q[j]}, {8'h00, dtyW_q[j]},
                      up_q[j], center_q, 1'b0, perInh);
          level[j] = r.level;
          if (chTick[j])
          begin
            cnt_d[j] = r.cnt[7:0];
            up_d[j] = r.up;
            roll[j] = r.roll;
          end
        end
      end
    end
    // a counter write forces the period to restart from zero unless clear inhibit is set
    for (int i = 0; i < 4; i++)
      if (wrCount[i] && !clrInh)
      begin
        cnt_d[i] = 8'h00;
        up_d[i] = 1'b1;
      end
  end

  // working latches follow the buffer when idle, on rollover or on counter write
  logic [7:0] perB_d [4], dtyB_d [4];
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      perB_d[i] = wrPeriod[i] ? apbReq.pwdata[7:0] : perB_q[i];
      dtyB_d[i] = wrDuty[i] ? apbReq.pwdata[7:0] : dtyB_q[i];
      perW_d[i] = perW_q[i];
      dtyW_d[i] = dtyW_q[i];
      if (roll[i] || wrCount[i] || !unitEn[i])
      begin
        perW_d[i] = perB_d[i];
        dtyW_d[i] = dtyB_d[i];
      end
    end
  end

  // pin drive: pwm only once the channel has seen its first clock tick
  logic [3:0] active_d, pwmPin, pinOut_d;
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      pwmPin[i] = !(joinPair[i/2] && i % 2 == 1);
      active_d[i] = unitEn[i] & (active_q[i] | chTick[i]);
      pinOut_d[i] = (active_d[i] && pwmPin[i]) ? ~(level[i] ^ polarity[i])
                                               : gpioData[i];
    end
  end
  assign pinOut  = pinOut_q;
  // enable overrides the direction bit without touching it
  assign pinOe_n = ~(enable_q | pinDirectionBits);

  // control registers, one to eight bits wide and all cleared at reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      concat_q <= fpw_pkg::RESET_BYTE;
      selPol_q <= fpw_pkg::RESET_BYTE;
      enable_q <= 4'h0;
      center_q <= 1'b0;
      test_q   <= 3'h0;
      pres_q   <= fpw_pkg::RESET_PRES;
    end
    else
    begin
      if (apbWr && addr == fpw_pkg::ADDR_CLK_CONCAT)
        concat_q <= apbReq.pwdata[7:0];
      if (apbWr && addr == fpw_pkg::ADDR_SEL_POL)
        selPol_q <= apbReq.pwdata[7:0];
      if (apbWr && addr == fpw_pkg::ADDR_ENABLE)
        enable_q <= apbReq.pwdata[3:0];
      if (apbWr && addr == fpw_pkg::ADDR_MODE)
        center_q <= apbReq.pwdata[fpw_pkg::POS_CENTER];
      // test bits exist only in special mode
      if (!specialModeFlag)
        test_q <= 3'h0;
      else if (apbWr && addr == fpw_pkg::ADDR_TEST)
        test_q <= apbReq.pwdata[2:0];
      pres_q <= pres_d;
    end
  end

  // scalers: down-counters on clock A/B, halved by a phase flop
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scal_q   <= '{default: fpw_pkg::RESET_BYTE};
      scnt_q   <= '{default: fpw_pkg::RESET_BYTE};
      sPhase_q <= 2'h0;
    end
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        if (scaleWr[p])
          scal_q[p] <= apbReq.pwdata[7:0];
        if (scaleWr[p] && !scalInh)
          scnt_q[p] <= apbReq.pwdata[7:0];
        else if (abTick[p])
          scnt_q[p] <= (scnt_q[p] == 8'h00) ? scal_q[p] : scnt_q[p] - 8'h01;
        if (abTick[p] && scnt_q[p] == 8'h00)
          sPhase_q[p] <= ~sPhase_q[p];
      end
    end
  end

  // channel state
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q    <= '{default: fpw_pkg::RESET_BYTE};
      perB_q   <= '{default: fpw_pkg::RESET_BYTE};
      perW_q   <= '{default: fpw_pkg::RESET_BYTE};
      dtyB_q   <= '{default: fpw_pkg::RESET_BYTE};
      dtyW_q   <= '{default: fpw_pkg::RESET_BYTE};
      up_q     <= 4'hF;
      active_q <= 4'h0;
      pinOut_q <= 4'h0;
    end
    else
    begin
      cnt_q    <= cnt_d;
      perB_q   <= perB_d;
      perW_q   <= perW_d;
      dtyB_q   <= dtyB_d;
      dtyW_q   <= dtyW_d;
      up_q     <= up_d;
      active_q <= active_d;
      pinOut_q <= pinOut_d;
    end
  end

  // checks on the clock chain and channel behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_presc_hold;
    !running && !presWr |=> $stable(pres_q);
  endproperty
  a_presc_hold: assert property (p_presc_hold) else $error("prescaler moved while idle");
  property p_presc_div2;
    running && presSel[0] == 3'h1 |-> abTick[0] == pres_q[0];
  endproperty
  a_presc_div2: assert property (p_presc_div2) else $error("clock A divide by two wrong");
  property p_scale_load;
    scaleWr[0] && !scalInh |=> scnt_q[0] == $past(apbReq.pwdata[7:0]);
  endproperty
  a_scale_load: assert property (p_scale_load) else $error("scale counter not loaded");
  property p_scale_reload;
    abTick[0] && scnt_q[0] == 8'h00 && !scaleWr[0] |=> scnt_q[0] == $past(scal_q[0]);
  endproperty
  a_scale_reload: assert property (p_scale_reload) else $error("scale counter reload wrong");
  property p_cnt_clear;
    wrCount[1] && !clrInh |=> cnt_q[1] == 8'h00 && perW_q[1] == perB_q[1];
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counter write did not clear");
  property p_cnt_keep;
    wrCount[0] && clrInh && !chTick[0] |=> $stable(cnt_q[0]);
  endproperty
  a_cnt_keep: assert property (p_cnt_keep) else $error("inhibited counter write cleared");
  property p_left_reset;
    chTick[0] && !joinPair[0] && !center_q && !perInh && !wrCount[0]
      && cnt_q[0] == perW_q[0] |=> cnt_q[0] == 8'h00;
  endproperty
  a_left_reset: assert property (p_left_reset) else $error("period match did not reset");
  property p_center_turn;
    chTick[0] && !joinPair[0] && center_q && up_q[0] && !wrCount[0]
      && perW_q[0] != 8'h00 && cnt_q[0] >= perW_q[0] |=> !up_q[0];
  endproperty
  a_center_turn: assert property (p_center_turn) else $error("center count did not turn");
  property p_oe_forced;
    enable_q[0] |-> !pinOe_n[0];
  endproperty
  a_oe_forced: assert property (p_oe_forced) else $error("enabled pin not driven");
  property p_late_start;
    $rose(enable_q[0]) && !joinPair[0] && !chTick[0] |=> !active_q[0];
  endproperty
  a_late_start: assert property (p_late_start) else $error("pwm before channel tick");

  c_joined_run: cover property (joinPair[0] && chTick[0] && roll[0]);
  c_center_roll: cover property (center_q && roll[1]);
  c_scaled_tick: cover property (sTick[0] && chTick[0]);
  c_buffered_load: cover property (unitEn[2] && wrDuty[2] ##[1:600] roll[2]);
endmodule
`default_nettype wire

// >>> core/fpw_pkg.sv
// constants, register map and carrier types for the four channel pwm core
`default_nettype none
package fpw_pkg;
  // register byte addresses on the apb bus
  localparam logic [7:0] ADDR_CLK_CONCAT = 8'h00;
  localparam logic [7:0] ADDR_SEL_POL    = 8'h04;
  localparam logic [7:0] ADDR_ENABLE     = 8'h08;
  localparam logic [7:0] ADDR_PRESCALE   = 8'h0C;
  localparam logic [7:0] ADDR_SCALE_VAL0 = 8'h10;
  localparam logic [7:0] ADDR_SCALE_CNT0 = 8'h14;
  localparam logic [7:0] ADDR_SCALE_VAL1 = 8'h18;
  localparam logic [7:0] ADDR_SCALE_CNT1 = 8'h1C;
  localparam logic [7:0] ADDR_MODE       = 8'h50;
  localparam logic [7:0] ADDR_TEST       = 8'h54;
  // per-channel register groups, four words each, channel in address bits 3:2
  localparam logic [3:0] GRP_COUNT       = 4'h2;
  localparam logic [3:0] GRP_PERIOD      = 4'h3;
  localparam logic [3:0] GRP_DUTY        = 4'h4;
  // field positions
  localparam int POS_PRESC_A   = 0;
  localparam int POS_PRESC_B   = 3;
  localparam int POS_JOIN_LOW  = 6;
  localparam int POS_JOIN_UP   = 7;
  localparam int POS_POL       = 0;
  localparam int POS_CLKSEL    = 4;
  localparam int POS_CENTER    = 0;
  localparam int POS_CLR_INH   = 0;
  localparam int POS_PER_INH   = 1;
  localparam int POS_SCAL_INH  = 2;
  // reset values and widths
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [6:0] RESET_PRES = 7'h00;
  localparam logic [6:0] PRES_FULL  = 7'h7F;
  // apb request carrier
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } fpw_apb_req_s;
  // result of one channel counter step
  typedef struct packed {
    logic [15:0] cnt;
    logic        up;
    logic        roll;
    logic        level;
  } fpw_step_s;
endpackage
`default_nettype wire

// >>> dv/fpw_pin_load.sv
// pin load model: resolves each port pin from the core's drive and enable
`timescale 1ns/1ps
`default_nettype none
module fpw_pin_load (
  input  wire logic       clk,      // sampling clock
  input  wire logic [3:0] pinOut,   // level the core drives
  input  wire logic [3:0] pinOe_n,  // low where the core drives
  output logic [3:0]      padLevel  // level seen on the pins
);
  logic [3:0] lastLevel_q = 4'h0;
  // pullups are off, so a released pin floats; it shows the inverse of its
  // last level so that a stale value can never pass for a driven one
  always @(posedge clk)
    lastLevel_q <= padLevel;
  assign padLevel = (~pinOe_n & pinOut) | (pinOe_n & ~lastLevel_q);
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// self-checking testbench for the four channel pwm core
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end \
  end
module testbench;
  localparam logic [7:0] CNT0 = {fpw_pkg::GRP_COUNT, 4'h0};
  localparam logic [7:0] CNT1 = {fpw_pkg::GRP_COUNT, 4'h4};
  localparam logic [7:0] PER0 = {fpw_pkg::GRP_PERIOD, 4'h0};
  localparam logic [7:0] PER1 = {fpw_pkg::GRP_PERIOD, 4'h4};
  localparam logic [7:0] DTY0 = {fpw_pkg::GRP_DUTY, 4'h0};
  localparam logic [7:0] DTY1 = {fpw_pkg::GRP_DUTY, 4'h4};
  logic                  clk;
  logic                  nrst;
  fpw_pkg::fpw_apb_req_s apbReq;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  specialModeFlag;
  logic [3:0]            pinDirectionBits;
  logic [3:0]            gpioData;
  logic [3:0]            pinOut;
  logic [3:0]            pinOe_n;
  logic [3:0]            padLevel;
  logic [31:0]           rdat;
  logic                  rerr;
  logic [31:0]           held;
  int                    err_total;
  int                    check_count;

  fpw_core u_dut (
    .clk              (clk),
    .nrst             (nrst),
    .apbReq           (apbReq),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .specialModeFlag  (specialModeFlag),
    .pinDirectionBits (pinDirectionBits),
    .gpioData         (gpioData),
    .pinOut           (pinOut),
    .pinOe_n          (pinOe_n)
  );

  fpw_pin_load u_load (
    .clk      (clk),
    .pinOut   (pinOut),
    .pinOe_n  (pinOe_n),
    .padLevel (padLevel)
  );

  // 100 MHz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // verdict and end of run
  task automatic conclude();
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one apb transfer; the request stays put until pready is seen at an edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    apbReq.psel    <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite  <= w;
    apbReq.paddr   <= a;
    apbReq.pwdata  <= {24'h000000, d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    // a slave that never answers is caught by the watchdog alone
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    apbReq.psel    <= 1'b0;
    apbReq.penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(a, 1'b0, 8'h00);
  endtask

  // set up channel 0, let it settle, then count high cycles on its pin;
  // windows span whole periods so the phase of the count does not matter
  task automatic run(input logic [7:0] cc, input logic [7:0] sp, input logic [7:0] md,
                     input logic [7:0] sc, input int win, input int hiExp);
    int hi;
    wr(fpw_pkg::ADDR_ENABLE, 8'h00);
    wr(fpw_pkg::ADDR_CLK_CONCAT, cc);
    wr(fpw_pkg::ADDR_SEL_POL, sp);
    wr(fpw_pkg::ADDR_MODE, md);
    wr(fpw_pkg::ADDR_SCALE_VAL0, sc);
    wr(CNT0, 8'h00);
    wr(fpw_pkg::ADDR_ENABLE, 8'h01);
    repeat (win) @(posedge clk);
    hi = 0;
    repeat (win)
    begin
      @(posedge clk);
      if (padLevel[0] === 1'b1)
        hi++;
    end
    `CHK("high cycles", 32'(hiExp), 32'(hi))
  endtask

  // main sequence
  initial
  begin
    nrst = 1'b0;
    apbReq = '0;
    specialModeFlag = 1'b0;
    pinDirectionBits = 4'h4;
    gpioData = 4'h6;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 80; a += 4)
    begin
      rd(8'(a));
      `CHK("reset value", 32'h00000000, rdat)
    end
    `CHK("gpio pin", 1'b1, padLevel[2])
    rd(8'h58);
    `CHK("unmapped error", 1'b1, rerr)
    // prescaler is frozen with every channel off, writable only in special mode
    wr(fpw_pkg::ADDR_PRESCALE, 8'h55);
    rd(fpw_pkg::ADDR_PRESCALE);
    `CHK("prescale normal write", 32'h00000000, rdat)
    specialModeFlag <= 1'b1;
    wr(fpw_pkg::ADDR_PRESCALE, 8'h55);
    repeat (20) @(posedge clk);
    rd(fpw_pkg::ADDR_PRESCALE);
    `CHK("prescale held", 32'h00000055, rdat)
    // divide by 128 never ticks while frozen at 55, so the scaler stays still
    wr(fpw_pkg::ADDR_CLK_CONCAT, 8'h07);
    wr(fpw_pkg::ADDR_SCALE_VAL0, 8'h37);
    rd(fpw_pkg::ADDR_SCALE_CNT0);
    `CHK("scale load", 32'h00000037, rdat)
    wr(fpw_pkg::ADDR_TEST, 8'h04);
    wr(fpw_pkg::ADDR_SCALE_VAL0, 8'h12);
    rd(fpw_pkg::ADDR_SCALE_CNT0);
    `CHK("scale load inhibited", 32'h00000037, rdat)
    wr(fpw_pkg::ADDR_TEST, 8'h00);
    specialModeFlag <= 1'b0;
    // waveform: period 4, duty 1
    wr(PER0, 8'h04);
    wr(DTY0, 8'h01);
    run(8'h00, 8'h01, 8'h00, 8'h00, 20, 8);
    run(8'h00, 8'h00, 8'h00, 8'h00, 20, 12);
    run(8'h01, 8'h01, 8'h00, 8'h00, 40, 16);
    run(8'h07, 8'h01, 8'h00, 8'h00, 2560, 1024);
    run(8'h02, 8'h11, 8'h00, 8'h01, 320, 128);
    run(8'h00, 8'h01, 8'h01, 8'h00, 32, 8);
    // counter reads, resume, clear and clear inhibit
    wr(fpw_pkg::ADDR_ENABLE, 8'h00);
    wr(fpw_pkg::ADDR_MODE, 8'h00);
    wr(PER0, 8'hFF);
    wr(CNT0, 8'h00);
    wr(fpw_pkg::ADDR_ENABLE, 8'h01);
    `CHK("pin driven", 1'b0, pinOe_n[0])
    repeat (100) @(posedge clk);
    wr(fpw_pkg::ADDR_ENABLE, 8'h00);
    `CHK("pin released", 1'b1, pinOe_n[0])
    rd(CNT0);
    held = rdat;
    rd(CNT0);
    `CHK("count stable", held, rdat)
    wr(fpw_pkg::ADDR_ENABLE, 8'h01);
    rd(CNT0);
    `CHK("count resumes", 1'b1, rdat > held)
    wr(fpw_pkg::ADDR_ENABLE, 8'h00);
    rd(CNT0);
    held = rdat;
    specialModeFlag <= 1'b1;
    wr(fpw_pkg::ADDR_TEST, 8'h01);
    wr(CNT0, 8'h00);
    rd(CNT0);
    `CHK("clear inhibited", held, rdat)
    wr(fpw_pkg::ADDR_TEST, 8'h00);
    specialModeFlag <= 1'b0;
    wr(CNT0, 8'h5A);
    rd(CNT0);
    `CHK("count cleared", 32'h00000000, rdat)
    // period match inhibit lets a left-aligned count run past its period
    specialModeFlag <= 1'b1;
    wr(fpw_pkg::ADDR_TEST, 8'h02);
    wr(PER0, 8'h04);
    wr(fpw_pkg::ADDR_ENABLE, 8'h01);
    repeat (20) @(posedge clk);
    wr(fpw_pkg::ADDR_ENABLE, 8'h00);
    rd(CNT0);
    `CHK("period match inhibited", 1'b1, rdat > 32'h00000004)
    wr(fpw_pkg::ADDR_TEST, 8'h00);
    specialModeFlag <= 1'b0;
    // joined lower pair: 16-bit period 0004, duty 0001, channel 1 on scaled clock
    wr(PER0, 8'h00);
    wr(DTY0, 8'h00);
    wr(PER1, 8'h04);
    wr(DTY1, 8'h01);
    wr(CNT1, 8'h00);
    run(8'h40, 8'h21, 8'h00, 8'h00, 40, 16);
    `CHK("low pin of pair", gpioData[1], pinOut[1])
    conclude();
  end

  // watchdog: the whole sequence needs well under this
  initial
  begin
    #300000;
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
